// file: design/qsm_cfg.svh
// register offsets, field positions and reset values of the quad serial master data ports
`ifndef QSM_CFG_SVH
`define QSM_CFG_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define QSM_STAT_OFS 8'h10
`define QSM_BCNT_OFS 8'h14
`define QSM_IEN_OFS 8'h18
`define QSM_TXP_OFS 8'h20
`define QSM_RXP_OFS 8'h24
`define QSM_DESC0_OFS 8'h30

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define QSM_TXERR_BIT 2
`define QSM_RXERR_BIT 3
`define QSM_RXCNT_LSB 16
`define QSM_TXCNT_LSB 0

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define QSM_STAT_RST 2'h0
`define QSM_IEN_RST 2'h0
`define QSM_DESC0_RST 32'h00000000
`define QSM_RDATA_RST 32'h00000000
`define QSM_TXBYTE_RST 8'h00

`endif

// file: design/qsm_pkg.sv
// types shared by the quad serial master data port files
package qsm_pkg;

  // ----------------------------------------------------------------------------
  // sticky error flags, high to low as in the status word
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic rx_err;
    logic tx_err;
  } qsm_err_t;

  // ----------------------------------------------------------------------------
  // buffer count status word
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] rx_cnt;
    logic [15:0] tx_cnt;
  } qsm_bcnt_t;

  // ----------------------------------------------------------------------------
  // register selected by a bus access
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    QSM_REG_NONE,
    QSM_REG_STAT,
    QSM_REG_BCNT,
    QSM_REG_IEN,
    QSM_REG_TXP,
    QSM_REG_RXP,
    QSM_REG_DESC0
  } qsm_reg_t;

endpackage

// file: design/qsm_byte_fifo.sv
// byte fifo that takes and gives up to four bytes per clock
`timescale 1ns/100ps
module qsm_byte_fifo import qsm_pkg::*; #(
  parameter int DEPTH = 16,
  parameter int CW = 16
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [2:0] push_n_in,
  input wire logic [31:0] push_data_in,
  input wire logic [2:0] pop_n_in,
  output logic [31:0] head_out,
  output logic [CW-1:0] count_out
);

  localparam int AW = $clog2(DEPTH);

  logic [7:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;

  // ----------------------------------------------------------------------------
  // storage, oldest byte of a word in the lowest lane
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 4; i++) begin
      if (3'(i) < push_n_in) begin
        mem[wr_ptr_r + AW'(i)] <= push_data_in[8*i +: 8];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // pointers and fill level; caller never over- or under-runs
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_r + AW'(push_n_in);
      rd_ptr_r <= rd_ptr_r + AW'(pop_n_in);
      count_r <= count_r + CW'(push_n_in) - CW'(pop_n_in);
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      head_out[8*i +: 8] = mem[rd_ptr_r + AW'(i)];
    end
  end

  assign count_out = count_r;

endmodule // qsm_byte_fifo

// file: design/qsm_data_ports.sv
// quad serial master transmit and receive data ports with wishbone register slave
// ----------------------------------------------------------------------------
// Summary of operation
// - every write to the transmit port that fits puts its bytes into the transmit fifo for the serial engine.
// - a write adds bytes up to its highest enabled lane: one for lane 0, two for lane 1 and four for lanes 2 or 3.
// - a write that does not fit the transmit fifo sets the sticky transmit error flag.
// - each accepted transmit write raises the transmit byte count by the bytes it added.
// - a read of the receive port returns received bytes and removes them from the receive fifo.
// - receive data comes back in the low lanes, bits 7:0 for a lane 0 byte and 15:0 for a lanes 1:0 halfword.
// - a read asking for more bytes than the receive fifo holds sets the sticky receive error flag.
// - each receive read lowers the receive byte count by the bytes it removed.
// - the count word shows receive bytes in bits 31:16 and transmit bytes in bits 15:0.
// ----------------------------------------------------------------------------
`timescale 1ns/100ps
`include "qsm_cfg.svh"
module qsm_data_ports import qsm_pkg::*; #(
  parameter int DEPTH = 16
) (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  output logic IRQ_OUT,
  input wire logic TX_REQ_IN,
  output logic [7:0] TX_BYTE_OUT,
  output logic TX_VALID_OUT,
  input wire logic RX_WR_IN,
  input wire logic [7:0] RX_BYTE_IN,
  output logic RX_FULL_OUT
);

  localparam int CW = 16;
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  // bytes carried by an access, from the byte enables
  function automatic logic [2:0] sel_bytes(input logic [3:0] sel);
    logic [2:0] n;
    n = 3'h1;
    if (sel[3] || sel[2]) begin
      n = 3'h4;
    end else if (sel[1]) begin
      n = 3'h2;
    end
    return n;
  endfunction

  // mask keeping the low lanes that an access of n bytes covers
  function automatic logic [31:0] lane_mask(input logic [2:0] n);
    logic [31:0] m;
    m = 32'h000000FF;
    if (n == 3'h4) begin
      m = 32'hFFFFFFFF;
    end else if (n == 3'h2) begin
      m = 32'h0000FFFF;
    end
    return m;
  endfunction

  function automatic qsm_reg_t reg_decode(input logic [7:0] adr);
    qsm_reg_t r;
    r = QSM_REG_NONE;
    case ({adr[7:2], 2'b00})
      `QSM_STAT_OFS: r = QSM_REG_STAT;
      `QSM_BCNT_OFS: r = QSM_REG_BCNT;
      `QSM_IEN_OFS: r = QSM_REG_IEN;
      `QSM_TXP_OFS: r = QSM_REG_TXP;
      `QSM_RXP_OFS: r = QSM_REG_RXP;
      `QSM_DESC0_OFS: r = QSM_REG_DESC0;
      default: r = QSM_REG_NONE;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------------
  logic ack_r;
  logic [31:0] rdata_r;
  logic irq_r;
  logic [7:0] tx_byte_r;
  logic tx_valid_r;
  logic rx_full_r;
  qsm_err_t err_r;
  qsm_err_t ien_r;
  logic [31:0] desc0_r;
  logic wb_req;
  qsm_reg_t wb_reg;
  logic [2:0] acc_n;
  logic tx_hit;
  logic rx_hit;
  logic tx_ovf;
  logic rx_undf;
  logic tx_wr_ok;
  logic rx_rd_ok;
  logic tx_pop;
  logic rx_push;
  logic stat_wr;
  logic [CW-1:0] tx_cnt;
  logic [CW-1:0] rx_cnt;
  logic [CW-1:0] tx_free;
  logic [CW-1:0] rx_cnt_nxt;
  logic [31:0] tx_head;
  logic [31:0] rx_head;
  logic [2:0] tx_push_n;
  logic [2:0] tx_pop_n;
  logic [2:0] rx_push_n;
  logic [2:0] rx_pop_n;
  qsm_bcnt_t bcnt;

  // ----------------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------------
  assign wb_req = WB_CYC_IN && WB_STB_IN && !ack_r;
  assign wb_reg = reg_decode(WB_ADR_IN);
  assign acc_n = sel_bytes(WB_SEL_IN);
  assign tx_hit = wb_req && WB_WE_IN && (wb_reg == QSM_REG_TXP);
  assign rx_hit = wb_req && !WB_WE_IN && (wb_reg == QSM_REG_RXP);
  assign stat_wr = wb_req && WB_WE_IN && (wb_reg == QSM_REG_STAT) && WB_SEL_IN[0];

  // ----------------------------------------------------------------------------
  // transmit port
  // ----------------------------------------------------------------------------
  assign tx_free = FULL_CNT - tx_cnt;
  assign tx_ovf = tx_hit && (CW'(acc_n) > tx_free);
  assign tx_wr_ok = tx_hit && !tx_ovf;
  assign tx_push_n = tx_wr_ok ? acc_n : 3'h0;
  assign tx_pop = TX_REQ_IN && (tx_cnt != '0);
  assign tx_pop_n = tx_pop ? 3'h1 : 3'h0;

  // write data taken from the low lanes only
  qsm_byte_fifo #(
    .DEPTH(DEPTH),
    .CW(CW)
  ) u_tx_fifo (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .push_n_in(tx_push_n),
    .push_data_in(WB_DAT_IN),
    .pop_n_in(tx_pop_n),
    .head_out(tx_head),
    .count_out(tx_cnt)
  );

  // one byte to the serial engine per request
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      tx_byte_r <= `QSM_TXBYTE_RST;
      tx_valid_r <= 1'b0;
    end else begin
      tx_valid_r <= tx_pop;
      if (tx_pop) begin
        tx_byte_r <= tx_head[7:0];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // receive port
  // ----------------------------------------------------------------------------
  assign rx_undf = rx_hit && (CW'(acc_n) > rx_cnt);
  assign rx_rd_ok = rx_hit && !rx_undf;
  assign rx_pop_n = rx_rd_ok ? acc_n : 3'h0;
  assign rx_push = RX_WR_IN && (rx_cnt != FULL_CNT);
  assign rx_push_n = rx_push ? 3'h1 : 3'h0;
  assign rx_cnt_nxt = rx_cnt + CW'(rx_push_n) - CW'(rx_pop_n);

  qsm_byte_fifo #(
    .DEPTH(DEPTH),
    .CW(CW)
  ) u_rx_fifo (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .push_n_in(rx_push_n),
    .push_data_in({24'h000000, RX_BYTE_IN}),
    .pop_n_in(rx_pop_n),
    .head_out(rx_head),
    .count_out(rx_cnt)
  );

  // full flag for the engine, bytes arriving while full are dropped
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rx_full_r <= 1'b0;
    end else begin
      rx_full_r <= (rx_cnt_nxt == FULL_CNT);
    end
  end

  // ----------------------------------------------------------------------------
  // sticky errors, set wins over a write-one clear
  // ----------------------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      err_r <= `QSM_STAT_RST;
    end else begin
      err_r.tx_err <= tx_ovf || (err_r.tx_err && !(stat_wr && WB_DAT_IN[`QSM_TXERR_BIT]));
      err_r.rx_err <= rx_undf || (err_r.rx_err && !(stat_wr && WB_DAT_IN[`QSM_RXERR_BIT]));
    end
  end

  // ----------------------------------------------------------------------------
  // interrupt mask, descriptor and level interrupt
  // ----------------------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ien_r <= `QSM_IEN_RST;
    end else if (wb_req && WB_WE_IN && (wb_reg == QSM_REG_IEN) && WB_SEL_IN[0]) begin
      ien_r.tx_err <= WB_DAT_IN[`QSM_TXERR_BIT];
      ien_r.rx_err <= WB_DAT_IN[`QSM_RXERR_BIT];
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      desc0_r <= `QSM_DESC0_RST;
    end else if (wb_req && WB_WE_IN && (wb_reg == QSM_REG_DESC0)) begin
      for (int i = 0; i < 4; i++) begin
        if (WB_SEL_IN[i]) begin
          desc0_r[8*i +: 8] <= WB_DAT_IN[8*i +: 8];
        end
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(err_r & ien_r);
    end
  end

  // ----------------------------------------------------------------------------
  // bus answer, one cycle after the request
  // ----------------------------------------------------------------------------
  assign bcnt.rx_cnt = rx_cnt;
  assign bcnt.tx_cnt = tx_cnt;

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_req;
    end
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rdata_r <= `QSM_RDATA_RST;
    end else if (wb_req) begin
      rdata_r <= 32'h00000000;
      if (!WB_WE_IN) begin
        case (wb_reg)
          QSM_REG_STAT: begin
            rdata_r[`QSM_TXERR_BIT] <= err_r.tx_err;
            rdata_r[`QSM_RXERR_BIT] <= err_r.rx_err;
          end
          QSM_REG_IEN: begin
            rdata_r[`QSM_TXERR_BIT] <= ien_r.tx_err;
            rdata_r[`QSM_RXERR_BIT] <= ien_r.rx_err;
          end
          QSM_REG_BCNT: rdata_r <= bcnt;
          QSM_REG_RXP: begin
            if (rx_rd_ok) begin
              rdata_r <= rx_head & lane_mask(acc_n);
            end
          end
          QSM_REG_DESC0: rdata_r <= desc0_r;
          default: rdata_r <= 32'h00000000;
        endcase
      end
    end
  end

  assign WB_ACK_OUT = ack_r;
  assign WB_DAT_OUT = rdata_r;
  assign IRQ_OUT = irq_r;
  assign TX_BYTE_OUT = tx_byte_r;
  assign TX_VALID_OUT = tx_valid_r;
  assign RX_FULL_OUT = rx_full_r;

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  chk_tx_push_bytes: assert property (
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    tx_wr_ok |-> tx_push_n == acc_n
  ) else $error("accepted transmit write did not push its bytes");

  chk_tx_count_add: assert property (
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    tx_wr_ok && !tx_pop |=> tx_cnt == $past(tx_cnt) + CW'($past(acc_n))
  ) else $error("transmit count did not rise by the write size");

  chk_tx_word_four: assert property (
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    tx_wr_ok && WB_SEL_IN == 4'hF && !tx_pop |=> tx_cnt == $past(tx_cnt) + 16'h0004
  ) else $error("word write did not add four bytes");

  chk_tx_ovf_flag: assert property (
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    tx_hit && (tx_cnt == FULL_CNT) |=> err_r.tx_err ##1 irq_r == ien_r.tx_err || irq_r
  ) else $error("write to full transmit fifo not flagged");

  chk_tx_ovf_hold: assert property (
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    tx_ovf && !tx_pop |=> tx_cnt == $past(tx_cnt)
  ) else $error("failed transmit write changed the fifo");

  chk_rx_undf_flag: assert property (
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    rx_undf |=> err_r.rx_err && WB_ACK_OUT && WB_DAT_OUT == 32'h00000000
  ) else $error("read from empty receive fifo not flagged");

  chk_rx_count_sub: assert property (
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    rx_rd_ok && !rx_push |=> rx_cnt == $past(rx_cnt) - CW'($past(acc_n))
  ) else $error("receive count did not fall by the read size");

  chk_rx_low_lanes: assert property (
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    rx_rd_ok && acc_n != 3'h4
    |=> WB_DAT_OUT[31:16] == 16'h0000 && ($past(acc_n) != 3'h1 || WB_DAT_OUT[15:8] == 8'h00)
  ) else $error("narrow receive read returned data above the low lanes");

  chk_rx_byte_order: assert property (
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    rx_rd_ok && acc_n == 3'h4 |=> WB_DAT_OUT == $past(rx_head)
  ) else $error("word read did not return four bytes oldest lowest");

  chk_err_sticky: assert property (
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    err_r.rx_err && !stat_wr |=> err_r.rx_err
  ) else $error("receive error flag dropped without a clear");

  chk_count_word: assert property (
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    wb_req && !WB_WE_IN && wb_reg == QSM_REG_BCNT
    |=> WB_DAT_OUT[31:16] == $past(rx_cnt) && WB_DAT_OUT[15:0] == $past(tx_cnt)
  ) else $error("count word does not match fifo levels");

  chk_ack_single: assert property (
    @(posedge CLK_IN) disable iff (!RSTN_IN)
    WB_ACK_OUT |=> !WB_ACK_OUT
  ) else $error("acknowledge held for more than one cycle");

endmodule // qsm_data_ports

// file: test/qsm_engine_model.sv
// behavioural serial engine model on the far side of the data ports
`timescale 1ns/100ps
module qsm_engine_model (
  input wire logic clk_in,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_byte_in,
  output logic tx_req_out,
  output logic rx_wr_out,
  output logic [7:0] rx_byte_out
);
  initial begin
    tx_req_out = 1'b0;
    rx_wr_out = 1'b0;
    rx_byte_out = 8'hFF;
  end

  // ----------------------------------------------------------------------------
  // pull one transmit byte, answer seen one cycle after the taking edge
  // ----------------------------------------------------------------------------
  task automatic pull(output logic [7:0] b, output logic v);
    @(posedge clk_in);
    tx_req_out <= 1'b1;
    @(posedge clk_in);
    tx_req_out <= 1'b0;
    @(posedge clk_in);
    v = tx_valid_in;
    b = tx_byte_in;
  endtask

  // ----------------------------------------------------------------------------
  // push one received byte; the data line is not left holding it
  // ----------------------------------------------------------------------------
  task automatic push(input logic [7:0] b);
    @(posedge clk_in);
    rx_wr_out <= 1'b1;
    rx_byte_out <= b;
    @(posedge clk_in);
    rx_wr_out <= 1'b0;
    rx_byte_out <= ~b;
  endtask
endmodule // qsm_engine_model

// file: test/tb_top.sv
// self-checking testbench of the quad serial master data ports
`timescale 1ns/100ps
`include "qsm_cfg.svh"
`define QCHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin errors++; \
  $display("unexpected %s expected %h seen %h", nm, ex, gt); end end
module tb_top;
  import qsm_pkg::*;
  localparam int DEPTH = 8;
  logic clk_in, rstn_in, cyc, stb, we, ack, irq, tx_req, tx_valid, rx_wr, rx_full;
  logic [7:0] adr, tx_byte, rx_byte;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  int errors = 0;
  int compares = 0;
  int cycles = 0;

  qsm_data_ports #(.DEPTH(DEPTH)) u_dut (.CLK_IN(clk_in), .RSTN_IN(rstn_in), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
    .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .IRQ_OUT(irq), .TX_REQ_IN(tx_req),
    .TX_BYTE_OUT(tx_byte), .TX_VALID_OUT(tx_valid), .RX_WR_IN(rx_wr), .RX_BYTE_IN(rx_byte),
    .RX_FULL_OUT(rx_full));
  qsm_engine_model u_eng (.clk_in(clk_in), .tx_valid_in(tx_valid), .tx_byte_in(tx_byte),
    .tx_req_out(tx_req), .rx_wr_out(rx_wr), .rx_byte_out(rx_byte));

  // ----------------------------------------------------------------------------
  // clock, timeout and verdict
  // ----------------------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      end_of_test();
    end
  end
  task end_of_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // classic wishbone single cycle
  // ----------------------------------------------------------------------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
                    output logic [31:0] r);
    @(posedge clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do begin
      @(posedge clk_in);
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [3:0] s, input logic [31:0] ex, input string nm);
    wb(1'b0, a, s, 32'h0, q);
    `QCHK(nm, ex, q)
  endtask

  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  task automatic t_reset();
    rd(`QSM_STAT_OFS, 4'hF, 32'h0, "status");
    rd(`QSM_BCNT_OFS, 4'hF, 32'h0, "count");
    rd(`QSM_IEN_OFS, 4'hF, 32'h0, "mask");
    rd(`QSM_TXP_OFS, 4'hF, 32'h0, "txport");
    rd(8'h3C, 4'hF, 32'h0, "unmapped");
    wb(1'b1, `QSM_DESC0_OFS, 4'hF, 32'hA5C3_0F1E, q);
    rd(`QSM_DESC0_OFS, 4'hF, 32'hA5C3_0F1E, "desc0");
    $display("test reset done");
  endtask

  task automatic t_tx();
    logic [7:0] exp_b[7] = '{8'h5A, 8'h4B, 8'h3C, 8'h01, 8'h02, 8'h03, 8'h04};
    logic [7:0] b;
    logic v;
    wb(1'b1, `QSM_TXP_OFS, 4'h1, 32'h0000_005A, q);
    rd(`QSM_BCNT_OFS, 4'hF, 32'h0000_0001, "count");
    wb(1'b1, `QSM_TXP_OFS, 4'h3, 32'h0000_3C4B, q);
    rd(`QSM_BCNT_OFS, 4'hF, 32'h0000_0003, "count");
    wb(1'b1, `QSM_TXP_OFS, 4'hF, 32'h0403_0201, q);
    rd(`QSM_BCNT_OFS, 4'hF, 32'h0000_0007, "count");
    for (int i = 0; i < 7; i++) begin
      u_eng.pull(b, v);
      `QCHK("txvalid", 1'b1, v)
      `QCHK("txbyte", exp_b[i], b)
    end
    rd(`QSM_BCNT_OFS, 4'hF, 32'h0, "count");
    $display("test transmit done");
  endtask

  task automatic t_tx_over();
    logic [7:0] b;
    logic v;
    wb(1'b1, `QSM_TXP_OFS, 4'hF, 32'h1413_1211, q);
    wb(1'b1, `QSM_TXP_OFS, 4'hF, 32'h1817_1615, q);
    wb(1'b1, `QSM_TXP_OFS, 4'h1, 32'h0000_00EE, q);
    rd(`QSM_STAT_OFS, 4'hF, 32'h0000_0004, "status");
    rd(`QSM_BCNT_OFS, 4'hF, 32'h0000_0008, "count");
    `QCHK("irq", 1'b0, irq)
    wb(1'b1, `QSM_IEN_OFS, 4'h1, 32'h0000_0004, q);
    repeat (2) @(posedge clk_in);
    `QCHK("irq", 1'b1, irq)
    rd(`QSM_STAT_OFS, 4'hF, 32'h0000_0004, "status");
    for (int i = 0; i < 8; i++) begin
      u_eng.pull(b, v);
      `QCHK("txbyte", 8'(8'h11 + i), b)
    end
    u_eng.pull(b, v);
    `QCHK("txvalid", 1'b0, v)
    wb(1'b1, `QSM_STAT_OFS, 4'h1, 32'h0000_0004, q);
    repeat (2) @(posedge clk_in);
    `QCHK("irq", 1'b0, irq)
    rd(`QSM_STAT_OFS, 4'hF, 32'h0, "status");
    $display("test transmit overflow done");
  endtask

  task automatic t_rx();
    logic [7:0] src[7] = '{8'hA1, 8'hB2, 8'hC3, 8'hD4, 8'hE5, 8'hF6, 8'h07};
    foreach (src[i]) u_eng.push(src[i]);
    rd(`QSM_BCNT_OFS, 4'hF, 32'h0007_0000, "count");
    rd(`QSM_RXP_OFS, 4'h1, 32'h0000_00A1, "rxbyte");
    rd(`QSM_BCNT_OFS, 4'hF, 32'h0006_0000, "count");
    rd(`QSM_RXP_OFS, 4'h3, 32'h0000_C3B2, "rxhalf");
    rd(`QSM_BCNT_OFS, 4'hF, 32'h0004_0000, "count");
    rd(`QSM_RXP_OFS, 4'hF, 32'h07F6_E5D4, "rxword");
    rd(`QSM_BCNT_OFS, 4'hF, 32'h0, "count");
    $display("test receive done");
  endtask

  task automatic t_rx_under();
    u_eng.push(8'h3D);
    rd(`QSM_RXP_OFS, 4'h3, 32'h0, "rxunder");
    rd(`QSM_STAT_OFS, 4'hF, 32'h0000_0008, "status");
    rd(`QSM_BCNT_OFS, 4'hF, 32'h0001_0000, "count");
    rd(`QSM_STAT_OFS, 4'hF, 32'h0000_0008, "status");
    rd(`QSM_RXP_OFS, 4'h1, 32'h0000_003D, "rxbyte");
    wb(1'b1, `QSM_STAT_OFS, 4'h1, 32'h0000_0008, q);
    rd(`QSM_STAT_OFS, 4'hF, 32'h0, "status");
    for (int i = 0; i < 9; i++) u_eng.push(8'(8'h60 + i));
    `QCHK("rxfull", 1'b1, rx_full)
    rd(`QSM_BCNT_OFS, 4'hF, 32'h0008_0000, "count");
    rd(`QSM_RXP_OFS, 4'hF, 32'h6362_6160, "rxword");
    `QCHK("rxfull", 1'b0, rx_full)
    rd(`QSM_RXP_OFS, 4'hF, 32'h6766_6564, "rxword");
    rd(`QSM_BCNT_OFS, 4'hF, 32'h0, "count");
    $display("test receive underflow done");
  endtask

  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    rstn_in = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    repeat (16) @(posedge clk_in);
    rstn_in <= 1'b1;
    t_reset();
    t_tx();
    t_tx_over();
    t_rx();
    t_rx_under();
    end_of_test();
  end
endmodule // tb_top
